// File: shared/sof_pkg.sv
// sof_pkg: constants and types of the sts-48 overhead framer
// assumes sys_clk is the serialiser byte clock; word timing is divided from it
// Operation
// - each row starts with 144 overhead bytes, carried as 36 words.
// - transparent mode passes user overhead bytes unchanged; the error settings still invert A1/A2 and B1 there.
// - user sends whole frame; overwrites happen before scrambler and serialiser.
// - section mode inserts A1=F6, A2=28, B1 in first STS-1, 00 elsewhere.
// - framing insertion and parity insertion have separate enables.
// - full mode generates all overhead; unlisted bytes are zero.
// - full mode J0 carries STS-1 id every fourth STS-1, else zero.
// - full mode F1 carries link number in first STS-1, else zero.
// - full mode H1/H2 are 62/0A first, 93/FF in other STS-1s.
// - full mode K2 first STS-1 is 06 on remote defect, else 00.
// - error settings invert A1/A2 bytes and invert transmitted B1.
// - force remote defect overwrites K2 with 00000110, also in section mode.
// - scrambler uses 1+x^6+x^7 on words, bypassed by scramble disable.
// - 32-bit words become bytes through a small elastic store.
// - word timing is the byte clock divided by four.
// - each of nine rows is 36 overhead then 1044 payload words.
// - receive bytes are grouped into unaligned words by divide-by-four.
// - framer outputs aligned words and a one-cycle frame pulse.
// - search four A1 then four A2; rotate bytes where F628 found.
// - reset to out-of-frame; in-frame after 2 good, out after 4 bad.
// - fast framing: one good pattern locks, one bad frame drops.
// - computed parity goes into B1 of the following frame.
// - all bytes are scrambled except A1, A2 and J0.
package sof_pkg;
    localparam int unsigned OVH_WORDS = 36;
    localparam int unsigned ROW_WORDS = 1080;
    localparam int unsigned ROWS = 9;
    localparam int unsigned FRAME_WORDS = 9720;
    localparam int unsigned FCW = 14;
    localparam int unsigned GOOD_TO_LOCK = 2;
    localparam int unsigned BAD_TO_DROP = 4;
    localparam logic [7:0] STS_N = 8'd48;
    localparam logic [7:0] A1_VAL = 8'hF6;
    localparam logic [7:0] A2_VAL = 8'h28;
    localparam logic [7:0] H1_FIRST = 8'h62;
    localparam logic [7:0] H2_FIRST = 8'h0A;
    localparam logic [7:0] H1_CONC = 8'h93;
    localparam logic [7:0] H2_CONC = 8'hFF;
    localparam logic [7:0] K2_RDI = 8'h06;
    localparam logic [6:0] SCR_SEED = 7'h7F;
    localparam int unsigned AW = 4;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STAT = 4'h4;
    localparam logic [3:0] ADDR_ERRS = 4'h8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam int unsigned C_MODE = 0;
    localparam int unsigned C_A1A2_EN = 2;
    localparam int unsigned C_B1_EN = 3;
    localparam int unsigned C_A1A2_ERR = 4;
    localparam int unsigned C_B1_ERR = 5;
    localparam int unsigned C_RDI = 6;
    localparam int unsigned C_SCR_DIS = 7;
    localparam int unsigned C_FAST = 8;
    localparam int unsigned C_AIS = 9;
    localparam int unsigned C_LINK = 16;
    localparam int unsigned S_OOF = 0;
    localparam int unsigned S_STICKY = 1;
    localparam int unsigned S_ROT = 4;
    localparam int unsigned S_ROW = 8;
    typedef enum logic [1:0] {SOF_TRANSP, SOF_SECT, SOF_FULL} sof_mode_e;
    typedef enum logic [1:0] {SOF_HUNT, SOF_PRESYNC, SOF_INFRAME} sof_frm_e;
endpackage

// File: rtl/sof_scrambler.sv
// sof_scrambler: frame-synchronous word scrambler
// assumes advance is a one-cycle word strobe from the owning module
`timescale 1ns/1ps
module sof_scrambler (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // word stream
    input wire logic advance,
    input wire logic load_seed,
    input wire logic bypass,
    input wire logic [31:0] word_in,
    output logic [31:0] word_out
);
    import sof_pkg::*;
    typedef struct packed {
        logic [6:0] lfsr;
        logic [31:0] word;
    } sof_scr_s;
    sof_scr_s st_q, st_d;

    always_comb begin
        logic [6:0] s;
        logic [31:0] ks;
        s = st_q.lfsr;
        ks = '0;
        st_d = st_q;
        // msb byte goes out first
        for (int i = 31; i >= 0; i--) begin
            ks[i] = s[6];
            s = {s[5:0], s[6] ^ s[5]};
        end
        if (advance) begin
            st_d.word = bypass ? word_in : (word_in ^ ks);
            st_d.lfsr = load_seed ? SCR_SEED : s;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
            st_q.lfsr <= SCR_SEED;
        end else begin
            st_q <= st_d;
        end
    end

    assign word_out = st_q.word;
endmodule

// File: rtl/sof_rx_demux.sv
// sof_rx_demux: groups deserialiser bytes into unaligned 32-bit words
// assumes one byte per sys_clk from a deserialiser on the same clock
`timescale 1ns/1ps
module sof_rx_demux (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // byte side
    input wire logic [7:0] byte_in,
    // word side
    output logic [31:0] word_out,
    output logic word_tick
);
    typedef struct packed {
        logic [1:0] div;
        logic [23:0] sh;
        logic [31:0] word;
        logic tick;
    } sof_dmx_s;
    sof_dmx_s st_q, st_d;

    always_comb begin
        st_d = st_q;
        st_d.div = st_q.div + 2'd1;
        st_d.sh = {st_q.sh[15:0], byte_in};
        st_d.tick = (st_q.div == 2'd3);
        // arbitrary byte phase; framer rotates
        if (st_q.div == 2'd3) begin
            st_d.word = {st_q.sh, byte_in};
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign word_out = st_q.word;
    assign word_tick = st_q.tick;
endmodule

// File: rtl/sof_framer_top.sv
// sof_framer_top: sts-48 transmit overhead, scrambler, serialiser and receive framer
// assumes user logic, serdes byte paths and register master all run on sys_clk
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module sof_framer_top #(
    parameter int unsigned FRAME_WORDS = sof_pkg::FRAME_WORDS
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire logic [sof_pkg::AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // transmit user side
    input wire logic [31:0] tx_data_in,
    input wire logic tx_frame_pulse_in,
    output logic tx_word_ready,
    // transmit serdes side
    output logic [7:0] tx_byte_out,
    // receive serdes side
    input wire logic [7:0] rx_byte_in,
    // receive user side
    output logic [31:0] rx_word_out,
    output logic rx_word_valid,
    output logic rx_frame_pulse,
    output logic rx_oof_alarm
);
    import sof_pkg::*;

    generate
        if (FRAME_WORDS < 16 || FRAME_WORDS > (1 << FCW)) begin : g_chk
            $error("FRAME_WORDS out of range");
        end
    endgenerate

    localparam logic [FCW-1:0] FW_LAST = FCW'(FRAME_WORDS - 1);
    localparam logic [10:0] ROW_LAST = 11'(ROW_WORDS - 1);
    localparam logic [10:0] OVH_LAST = 11'(OVH_WORDS - 1);
    localparam logic [10:0] OVH_END = 11'(OVH_WORDS);
    localparam logic [3:0] ROW_MAX = 4'(ROWS - 1);
    localparam logic [1:0] GOOD_N = 2'(GOOD_TO_LOCK);
    localparam logic [2:0] BAD_N = 3'(BAD_TO_DROP);

    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] rdata;
        logic [1:0] div;
        logic [10:0] col;
        logic [3:0] row;
        logic first;
        logic [7:0] bip;
        logic [7:0] b1;
        logic [31:0] store;
        logic [31:0] shift;
        logic [7:0] txb;
        logic [95:0] hist;
        sof_frm_e fsm;
        logic [1:0] rot;
        logic [FCW-1:0] wcnt;
        logic [1:0] good;
        logic [2:0] bad;
        logic oof_sticky;
        logic [15:0] errs;
        logic [31:0] rxw;
        logic rxv;
        logic rxfp;
    } sof_top_s;

    sof_top_s st_q, st_d;
    logic [1:0] rst_sync_q;
    logic rst_int_b;
    logic tick;
    logic [10:0] pos_col;
    logic [3:0] pos_row;
    logic in_ovh;
    logic [31:0] ovh_word;
    logic [31:0] scr_word;
    logic scr_bypass;
    logic scr_seed;
    logic [31:0] dmx_word;
    logic dmx_tick;

    // two-flop release avoids a ragged reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_int_b = rst_sync_q[1];

    // one overhead byte
    function automatic logic [7:0] ovh_byte(
        input logic [3:0] row,
        input logic [7:0] b,
        input logic [7:0] ub,
        input logic [31:0] c,
        input logic [7:0] b1v
    );
        logic [1:0] oc;
        logic [7:0] sts;
        logic fst;
        logic [7:0] v;
        sof_mode_e m;
        oc = (b >= 2 * STS_N) ? 2'd2 : ((b >= STS_N) ? 2'd1 : 2'd0);
        sts = (oc == 2'd2) ? 8'(b - 2 * STS_N) : ((oc == 2'd1) ? (b - STS_N) : b);
        fst = (sts == 8'h00);
        m = sof_mode_e'(c[C_MODE +: 2]);
        v = ub;
        case (m)
            SOF_SECT: begin
                if (c[C_A1A2_EN] && row == 4'd0 && oc != 2'd2) begin
                    v = (oc == 2'd0) ? A1_VAL : A2_VAL;
                end
                if (c[C_B1_EN] && row == 4'd1 && oc == 2'd0) begin
                    v = fst ? b1v : 8'h00;
                end
            end
            SOF_FULL: begin
                v = 8'h00;
                case (row)
                    4'd0: begin
                        if (oc == 2'd0) begin
                            v = A1_VAL;
                        end else if (oc == 2'd1) begin
                            v = A2_VAL;
                        end else if (sts[1:0] == 2'b00) begin
                            v = sts + 8'h01;
                        end
                    end
                    4'd1: begin
                        if (oc == 2'd0 && fst) begin
                            v = b1v;
                        end else if (oc == 2'd2 && fst) begin
                            v = c[C_LINK +: 8];
                        end
                    end
                    4'd3: begin
                        if (oc == 2'd0) begin
                            v = fst ? H1_FIRST : H1_CONC;
                        end else if (oc == 2'd1) begin
                            v = fst ? H2_FIRST : H2_CONC;
                        end
                    end
                    default: begin
                        v = 8'h00;
                    end
                endcase
            end
            default: begin
                v = ub;
            end
        endcase
        // K2 only where the block owns it
        if ((m == SOF_SECT || m == SOF_FULL) && c[C_RDI] && row == 4'd4 && oc == 2'd2 && fst) begin
            v = K2_RDI;
        end
        if (c[C_A1A2_ERR] && row == 4'd0 && oc != 2'd2) begin
            v = ~v;
        end
        if (c[C_B1_ERR] && row == 4'd1 && oc == 2'd0 && fst) begin
            v = ~v;
        end
        return v;
    endfunction

    // framing match at rotation r
    function automatic logic fr_match(
        input logic [95:0] h,
        input logic [1:0] r
    );
        logic [63:0] w;
        w = h[7'd95 - {2'b00, r, 3'b000} -: 64];
        return w == {{4{A1_VAL}}, {4{A2_VAL}}};
    endfunction

    // word position, restarted by frame pulse
    assign tick = (st_q.div == 2'd0);
    assign pos_col = tx_frame_pulse_in ? 11'd0 : st_q.col;
    assign pos_row = tx_frame_pulse_in ? 4'd0 : st_q.row;
    assign in_ovh = (pos_col < OVH_END);

    always_comb begin
        ovh_word = tx_data_in;
        for (int l = 0; l < 4; l++) begin
            if (in_ovh) begin
                ovh_word[31 - 8 * l -: 8] = ovh_byte(pos_row, {pos_col[5:0], 2'(l)},
                    tx_data_in[31 - 8 * l -: 8], st_q.ctrl, st_q.b1);
            end
        end
    end

    // A1, A2 and J0 words of row 0 go out unscrambled
    assign scr_bypass = st_q.ctrl[C_SCR_DIS] || (pos_row == 4'd0 && in_ovh);
    assign scr_seed = (pos_row == 4'd0 && pos_col == OVH_LAST);

    sof_scrambler u_scr (
        .sys_clk(sys_clk),
        .rst_b(rst_int_b),
        .advance(tick),
        .load_seed(scr_seed),
        .bypass(scr_bypass),
        .word_in(ovh_word),
        .word_out(scr_word)
    );

    sof_rx_demux u_dmx (
        .sys_clk(sys_clk),
        .rst_b(rst_int_b),
        .byte_in(rx_byte_in),
        .word_out(dmx_word),
        .word_tick(dmx_tick)
    );

    always_comb begin
        logic [95:0] h;
        logic found;
        logic [1:0] fr;
        logic expect_fp;
        logic ok;
        logic [31:0] rd;
        h = {st_q.hist[63:0], dmx_word};
        found = 1'b0;
        fr = 2'd0;
        expect_fp = (st_q.wcnt == FW_LAST);
        ok = fr_match(h, st_q.rot);
        rd = 32'h0000_0000;
        st_d = st_q;

        // transmit sequencing
        st_d.div = st_q.div + 2'd1;
        if (tick) begin
            st_d.first = tx_frame_pulse_in;
            if (pos_col == ROW_LAST) begin
                st_d.col = 11'd0;
                st_d.row = (pos_row == ROW_MAX) ? 4'd0 : pos_row + 4'd1;
            end else begin
                st_d.col = pos_col + 11'd1;
                st_d.row = pos_row;
            end
        end

        // parity over scrambled words, sent a frame later
        if (st_q.div == 2'd1) begin
            st_d.store = scr_word;
            if (st_q.first) begin
                st_d.b1 = st_q.bip;
                st_d.bip = scr_word[31:24] ^ scr_word[23:16] ^ scr_word[15:8] ^ scr_word[7:0];
            end else begin
                st_d.bip = st_q.bip ^ scr_word[31:24] ^ scr_word[23:16] ^ scr_word[15:8] ^ scr_word[7:0];
            end
        end

        // one store word per four byte clocks
        if (st_q.div == 2'd3) begin
            st_d.shift = st_q.store;
        end
        st_d.txb = st_q.shift[{2'd3 - st_q.div, 3'b000} +: 8];

        // receive framer
        st_d.rxv = dmx_tick;
        st_d.rxfp = 1'b0;
        if (dmx_tick) begin
            st_d.hist = h;
            st_d.wcnt = expect_fp ? '0 : st_q.wcnt + 1'b1;
            for (int r = 3; r >= 0; r--) begin
                if (fr_match(h, 2'(r))) begin
                    found = 1'b1;
                    fr = 2'(r);
                end
            end
            case (st_q.fsm)
                SOF_HUNT: begin
                    if (found) begin
                        st_d.rot = fr;
                        st_d.wcnt = '0;
                        st_d.good = 2'd1;
                        st_d.bad = 3'd0;
                        st_d.rxfp = 1'b1;
                        st_d.fsm = st_q.ctrl[C_FAST] ? SOF_INFRAME : SOF_PRESYNC;
                    end
                end
                SOF_PRESYNC: begin
                    if (expect_fp) begin
                        if (ok) begin
                            st_d.rxfp = 1'b1;
                            st_d.good = st_q.good + 2'd1;
                            if (st_q.good + 2'd1 >= GOOD_N || st_q.ctrl[C_FAST]) begin
                                st_d.fsm = SOF_INFRAME;
                            end
                        end else begin
                            st_d.fsm = SOF_HUNT;
                            st_d.good = 2'd0;
                        end
                    end
                end
                SOF_INFRAME: begin
                    if (expect_fp) begin
                        st_d.rxfp = 1'b1;
                        if (ok) begin
                            st_d.bad = 3'd0;
                        end else begin
                            st_d.bad = st_q.bad + 3'd1;
                            if (st_q.errs != 16'hFFFF) begin
                                st_d.errs = st_q.errs + 16'h0001;
                            end
                            // frame timing kept meanwhile
                            if (st_q.bad + 3'd1 >= BAD_N || st_q.ctrl[C_FAST]) begin
                                st_d.fsm = SOF_HUNT;
                                st_d.good = 2'd0;
                                st_d.rxfp = 1'b0;
                            end
                        end
                    end
                end
                default: begin
                    st_d.fsm = SOF_HUNT;
                end
            endcase
            // optional all-ones fill out of frame
            if (st_q.ctrl[C_AIS] && st_q.fsm != SOF_INFRAME) begin
                st_d.rxw = 32'hFFFF_FFFF;
            end else begin
                st_d.rxw = h[7'd63 - {2'b00, st_d.rot, 3'b000} -: 32];
            end
        end

        // register writes
        if (reg_wr && reg_addr == ADDR_CTRL) begin
            st_d.ctrl = reg_wdata;
        end
        if (reg_wr && reg_addr == ADDR_STAT && reg_wdata[S_STICKY]) begin
            st_d.oof_sticky = 1'b0;
        end
        if (reg_wr && reg_addr == ADDR_ERRS) begin
            st_d.errs = 16'(st_d.errs != st_q.errs);
        end
        // set beats a clear in the same cycle
        if (st_q.fsm == SOF_INFRAME && st_d.fsm == SOF_HUNT) begin
            st_d.oof_sticky = 1'b1;
        end

        // register reads, valid the cycle after the strobe only
        case (reg_addr)
            ADDR_CTRL: rd = st_q.ctrl;
            ADDR_STAT: begin
                rd[S_OOF] = (st_q.fsm != SOF_INFRAME);
                rd[S_STICKY] = st_q.oof_sticky;
                rd[S_ROT +: 2] = st_q.rot;
                rd[S_ROW +: 4] = st_q.row;
            end
            ADDR_ERRS: rd = {16'h0000, st_q.errs};
            default: rd = 32'h0000_0000;
        endcase
        st_d.rdata = reg_rd ? rd : 32'h0000_0000;
    end

    always_ff @(posedge sys_clk or negedge rst_int_b) begin
        if (!rst_int_b) begin
            st_q <= '0;
            st_q.ctrl <= CTRL_RST;
            st_q.fsm <= SOF_HUNT;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign tx_word_ready = tick;
    assign tx_byte_out = st_q.txb;
    assign rx_word_out = st_q.rxw;
    assign rx_word_valid = st_q.rxv;
    assign rx_frame_pulse = st_q.rxfp;
    assign rx_oof_alarm = (st_q.fsm != SOF_INFRAME);
endmodule

// File: test/sof_framer_chk.sv
// sof_framer_chk: port assertions for sof_framer_top
// assumes one clock, ais fill off
`timescale 1ns/1ps
module sof_framer_chk
    import sof_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port
    input wire logic [AW-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // transmit
    input wire logic [31:0] tx_data_in,
    input wire logic tx_frame_pulse_in,
    input wire logic tx_word_ready,
    input wire logic [7:0] tx_byte_out,
    // receive
    input wire logic [7:0] rx_byte_in,
    input wire logic [31:0] rx_word_out,
    input wire logic rx_word_valid,
    input wire logic rx_frame_pulse,
    input wire logic rx_oof_alarm
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    reset_alarm_a: assert property ($rose(rst_b) |-> rx_oof_alarm)
        else $error("alarm low at reset release");
    fp_single_a: assert property (rx_frame_pulse |=> !rx_frame_pulse)
        else $error("frame pulse longer than one cycle");
    fp_word_a: assert property (rx_frame_pulse |-> rx_word_valid && rx_word_out == {4{A2_VAL}})
        else $error("pulse not on A2 word");
    valid_spacing_a: assert property (rx_word_valid |=> !rx_word_valid [*3] ##1 rx_word_valid)
        else $error("rx valid not one in four");
    // ready is also high in reset
    ready_spacing_a: assert property (tx_word_ready && $past(rst_b, 3) |=> !tx_word_ready [*3] ##1 tx_word_ready)
        else $error("ready not one in four");
    lock_pattern_a: assert property ($fell(rx_oof_alarm) |-> rx_frame_pulse || $past(rx_frame_pulse) ||
        $past(rx_frame_pulse, 2))
        else $error("lock without a framing pattern");
    stat_live_a: assert property ($past(reg_rd) && $past(reg_addr) == ADDR_STAT |->
        reg_rdata[S_OOF] == $past(rx_oof_alarm))
        else $error("status oof bit wrong");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data not idle");
endmodule
bind sof_framer_top sof_framer_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_data_in(tx_data_in), .tx_frame_pulse_in(tx_frame_pulse_in), .tx_word_ready(tx_word_ready),
    .tx_byte_out(tx_byte_out), .rx_byte_in(rx_byte_in), .rx_word_out(rx_word_out),
    .rx_word_valid(rx_word_valid), .rx_frame_pulse(rx_frame_pulse), .rx_oof_alarm(rx_oof_alarm));

// File: test/sof_user_model.sv
// sof_user_model: user logic sending whole transmit frames
// assumes tx_word_ready is the word strobe on sys_clk
`timescale 1ns/1ps
module sof_user_model #(
    parameter int unsigned WORDS = 9720
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // word side
    input wire logic tx_word_ready,
    output logic [31:0] tx_data_in,
    output logic tx_frame_pulse_in
);
    logic [15:0] w_q;
    logic [3:0] rs_q;
    // same clock: frequency lock holds
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            w_q <= 16'h0;
            rs_q <= 4'h0;
        end else begin
            rs_q <= {rs_q[2:0], 1'b1};
            // first frame start held until the bench has set ctrl
            if (tx_word_ready && rs_q[3])
                w_q <= (w_q == 16'(WORDS - 1)) ? 16'h0 : w_q + 16'h1;
        end
    end
    assign tx_data_in = {w_q, w_q ^ 16'hC3A5};
    assign tx_frame_pulse_in = (w_q == 16'h0);
endmodule

// File: test/tb_top.sv
// tb_top: self-checking bench for sof_framer_top
// assumes the user model feeds words
`timescale 1ns/1ps
module tb_top;
    import sof_pkg::*;
    localparam int FW = 64;
    localparam int RB = 4320;
    localparam int CAPN = 8 * RB + 200;
    logic sys_clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [AW-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic [31:0] reg_rdata, tx_data_in, rx_word_out, rd_v;
    logic tx_frame_pulse_in, tx_word_ready, rx_word_valid, rx_frame_pulse, rx_oof_alarm;
    logic [7:0] tx_byte_out, link;
    logic [7:0] rx_byte_in = 8'h0;
    logic rx_on = 1'b0, rx_bad = 1'b0, cap_on = 1'b0;
    logic [7:0] cap [0:CAPN];
    int err_total = 0, cmp_count = 0, lat = -1, rx_i = 1, cap_n = 0;
    always #4 sys_clk = ~sys_clk;
    sof_framer_top #(.FRAME_WORDS(FW)) u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tx_data_in(tx_data_in), .tx_frame_pulse_in(tx_frame_pulse_in), .tx_word_ready(tx_word_ready),
        .tx_byte_out(tx_byte_out), .rx_byte_in(rx_byte_in), .rx_word_out(rx_word_out),
        .rx_word_valid(rx_word_valid), .rx_frame_pulse(rx_frame_pulse), .rx_oof_alarm(rx_oof_alarm));
    sof_user_model u_user (.sys_clk(sys_clk), .rst_b(rst_b), .tx_word_ready(tx_word_ready),
        .tx_data_in(tx_data_in), .tx_frame_pulse_in(tx_frame_pulse_in));
    // short rx frames; payload never holds F6
    always @(posedge sys_clk) begin
        rx_i <= (rx_i == 4 * FW - 1) ? 0 : rx_i + 1;
        if (rx_on && rx_i < 48)
            rx_byte_in <= rx_bad ? 8'hF4 : A1_VAL;
        else if (rx_on && rx_i < 96)
            rx_byte_in <= A2_VAL;
        else
            rx_byte_in <= 8'($urandom) & 8'h7F;
    end
    always @(posedge sys_clk)
        if (cap_on && cap_n < CAPN) begin
            cap[cap_n] <= tx_byte_out;
            cap_n <= cap_n + 1;
        end
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [AW-1:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        d = reg_rdata;
    endtask
    task automatic wait_fp();
        int n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (rx_frame_pulse !== 1'b1 && n < 2000);
        chk(n < 2000, 1'b1);
    endtask
    // expected byte; bit 8 marks unmodelled parity
    function automatic logic [8:0] exp_b(logic [31:0] c, int r, int b, logic [7:0] ub);
        int col = b / 48;
        int s = b % 48;
        logic full = (c[1:0] == 2'h2);
        logic sect = (c[1:0] == 2'h1);
        logic [7:0] v = (full && b < 144) ? 8'h0 : ub;
        if (b >= 144)
            return {1'b0, ub};
        if (r == 0 && col < 2 && (full || sect && c[C_A1A2_EN]))
            v = (col == 0) ? A1_VAL : A2_VAL;
        if (r == 0 && col < 2 && c[C_A1A2_ERR])
            v = ~v;
        if (r == 0 && col == 2 && full)
            v = (s % 4 == 0) ? 8'(s + 1) : 8'h0;
        if (r == 1 && col == 0 && (full || sect && c[C_B1_EN]))
            return (s == 0) ? 9'h100 : 9'h000;
        if (r == 1 && col == 2 && full && s == 0)
            v = c[23:16];
        if (r == 3 && col < 2 && full)
            v = (s == 0) ? (col == 0 ? H1_FIRST : H2_FIRST) : (col == 0 ? H1_CONC : H2_CONC);
        if (r == 4 && col == 2 && s == 0 && c[C_RDI] && (full || sect))
            v = K2_RDI;
        return {1'b0, v};
    endfunction
    // rows 0..4 under c0, 5..8 under c1
    task automatic tx_frame(input logic [31:0] c0, input logic [31:0] c1);
        logic [31:0] uw;
        logic [8:0] e;
        wr(ADDR_CTRL, c0);
        cap_n = 0;
        do @(posedge sys_clk);
        while (!(tx_word_ready && tx_frame_pulse_in));
        cap_on <= 1'b1;
        repeat (5 * RB - 2000) @(posedge sys_clk);
        wr(ADDR_CTRL, c1);
        wait (cap_n >= CAPN);
        cap_on <= 1'b0;
        for (int k = 15; k >= 0 && lat < 0; k--)
            if (cap[k + 47] === A1_VAL && cap[k + 48] === A2_VAL)
                lat = k;
        chk(lat >= 0, 1'b1);
        for (int r = 0; r < 9; r++)
            for (int b = 0; b < 160; b++) begin
                uw = {16'(r * 1080 + b / 4), 16'(r * 1080 + b / 4) ^ 16'hC3A5};
                e = exp_b(r < 5 ? c0 : c1, r, b, uw[31 - 8 * (b % 4) -: 8]);
                if (!e[8])
                    chk(cap[lat + r * RB + b], e[7:0]);
            end
    endtask
    initial begin
        #800000;
        err_total++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h39C2));
        repeat (16) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(rx_oof_alarm, 1'b1);
        link = 8'($urandom);
        tx_frame({8'h0, link, 16'h00C2}, 32'h83);
        tx_frame(32'hD5, 32'h80);
        rx_on <= 1'b1;
        wait_fp();
        repeat (8) @(posedge sys_clk);
        chk(rx_oof_alarm, 1'b1);
        wait_fp();
        repeat (8) @(posedge sys_clk);
        chk(rx_oof_alarm, 1'b0);
        rx_bad <= 1'b1;
        repeat (3 * 4 * FW + 128) @(posedge sys_clk);
        chk(rx_oof_alarm, 1'b0);
        repeat (4 * FW) @(posedge sys_clk);
        chk(rx_oof_alarm, 1'b1);
        rd(ADDR_STAT, rd_v);
        chk(rd_v[S_STICKY], 1'b1);
        wr(ADDR_STAT, 32'h2);
        rd(ADDR_STAT, rd_v);
        chk(rd_v[S_STICKY], 1'b0);
        rx_bad <= 1'b0;
        wr(ADDR_CTRL, 32'h180);
        rd(ADDR_CTRL, rd_v);
        chk(rd_v, 32'h180);
        wait_fp();
        repeat (8) @(posedge sys_clk);
        chk(rx_oof_alarm, 1'b0);
        rx_bad <= 1'b1;
        repeat (4 * FW + 128) @(posedge sys_clk);
        chk(rx_oof_alarm, 1'b1);
        wr(4'hC, $urandom);
        rd(4'hC, rd_v);
        chk(rd_v, 32'h0);
        report_and_stop();
    end
endmodule
